// File: wdsc_consts.vh
`ifndef WDSC_CONSTS_VH
`define WDSC_CONSTS_VH

// Register addresses
`define WDSC_AUX_ADDR 8'ha2
`define WDSC_WATCHDOG_CONTROL_REG_ADDR 8'ha7
`define WDSC_FEED_ADDR 8'ha6
`define WDSC_PTRL_ADDR 8'h82
`define WDSC_PTRH_ADDR 8'h83

// Feed codes
`define WDSC_FEED_FIRST 8'h1e
`define WDSC_FEED_SECOND 8'he1

// Auxiliary control field positions
`define WDSC_AUX_KBF 7
`define WDSC_AUX_BOD 6
`define WDSC_AUX_BOI 5
`define WDSC_AUX_EPROM_LOW_POWER 4
`define WDSC_AUX_SOFTWARE_RESET_BIT 3
`define WDSC_AUX_ZERO 2
`define WDSC_AUX_RSVD 1
`define WDSC_AUX_DPS 0
`define WDSC_AUX_RESET 8'h00

// Watchdog control field positions
`define WDSC_WATCHDOG_CONTROL_REG_SEL_LSB 0
`define WDSC_WATCHDOG_CONTROL_REG_SEL_MSB 2
`define WDSC_WATCHDOG_CONTROL_REG_FLAG 5
`define WDSC_WATCHDOG_CONTROL_REG_RESET 8'h00

// Timing
`define WDSC_CLK_MHZ 50
`define WDSC_TIMEOUT_MIN_MS 25
`define WDSC_TIMEOUT_MAX_MS 3200
`define WDSC_STARTUP_MS 10
`define WDSC_BASE_CYC (`WDSC_TIMEOUT_MIN_MS * `WDSC_CLK_MHZ * 1000)
`define WDSC_RST_PULSE_NS 1000
`define WDSC_RST_PULSE_CYC ((`WDSC_RST_PULSE_NS * `WDSC_CLK_MHZ) / 1000)
`define WDSC_CNT_WIDTH 28

`endif

// File: wdsc_ptr_bank.v
`timescale 1ns/1ps
`include "wdsc_consts.vh"

module wdsc_ptr_bank #(
  parameter WIDTH = 16
) (
  input wire ref_clk,
  input wire reset_n,
  input wire clear,
  input wire selNext,
  input wire incEn,
  input wire loadEn,
  input wire [WIDTH-1:0] loadData,
  input wire wrLowEn,
  input wire wrHighEn,
  input wire [7:0] wrByte,
  output reg [WIDTH-1:0] activePtr_reg
);

  reg [WIDTH-1:0] ptr0_reg;
  reg [WIDTH-1:0] ptr1_reg;
  reg [WIDTH-1:0] ptr0_next;
  reg [WIDTH-1:0] ptr1_next;
  reg [WIDTH-1:0] cur;
  reg [WIDTH-1:0] upd;

  // Only the pointer that selNext picks is touched; the other keeps its value unless clear zeros both
  always @* begin
    cur = selNext ? ptr1_reg : ptr0_reg;
    upd = cur;
    if (loadEn) begin
      upd = loadData;
    end else if (incEn) begin
      upd = cur + {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (wrLowEn) begin
      upd = {cur[WIDTH-1:8], wrByte};
    end else if (wrHighEn) begin
      upd = {wrByte, cur[7:0]};
    end
    ptr0_next = selNext ? ptr0_reg : upd;
    ptr1_next = selNext ? upd : ptr1_reg;
    if (clear) begin
      ptr0_next = {WIDTH{1'b0}};
      ptr1_next = {WIDTH{1'b0}};
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr0_reg <= {WIDTH{1'b0}};
      ptr1_reg <= {WIDTH{1'b0}};
      activePtr_reg <= {WIDTH{1'b0}};
    end else begin
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next;
      activePtr_reg <= selNext ? ptr1_next : ptr0_next;
    end
  end

endmodule

// File: wdsc_top.v
`timescale 1ns/1ps
`include "wdsc_consts.vh"

module wdsc_top #(
  parameter [`WDSC_CNT_WIDTH-1:0] BASE_CYCLES = `WDSC_BASE_CYC,
  parameter PTR_WIDTH = 16
) (
  input wire ref_clk,
  input wire reset_n,
  input wire watchdogEnableCfg,
  input wire otherResetIn,
  input wire powerDownIn,
  input wire oscStableIn,
  input wire keypadEventIn,
  input wire wdtIrqEnable,
  input wire [7:0] sfrAddr,
  input wire sfrWrEn,
  input wire [7:0] sfrWrData,
  input wire ptrIncEn,
  input wire ptrLoadEn,
  input wire [PTR_WIDTH-1:0] ptrLoadData,
  output reg [7:0] sfrRdData_reg,
  output reg chipResetOut_reg,
  output reg oscRestartReq_reg,
  output reg wdtIrq_reg,
  output reg brownoutDetectEn_reg,
  output reg brownoutIrqSelect_reg,
  output reg epromLowPower_reg,
  output wire [PTR_WIDTH-1:0] activePointer
);

  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_PULSE = 3'b010;
  localparam [2:0] ST_WAIT_OSC = 3'b100;
  localparam integer PULSE_LAST_INT = `WDSC_RST_PULSE_CYC - 1;
  localparam [7:0] PULSE_LAST = PULSE_LAST_INT[7:0];
  localparam [7:0] WATCHDOG_CONTROL_REG_RST = `WDSC_WATCHDOG_CONTROL_REG_RESET;
  localparam [7:0] AUX_RST = `WDSC_AUX_RESET;
  localparam CW = `WDSC_CNT_WIDTH;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [CW-1:0] count_reg;
  reg [CW-1:0] count_next;
  reg [7:0] pulseCnt_reg;
  reg [7:0] pulseCnt_next;
  reg pdLatched_reg;
  reg pdLatched_next;
  reg wdEnable_reg;
  reg cfgLoaded_reg;
  reg feedArmed_reg;
  reg feedArmed_next;
  reg wdconLocked_reg;
  reg wdconLocked_next;
  reg [2:0] timeoutSelect_reg;
  reg [2:0] timeoutSelect_next;
  reg intervalFlag_reg;
  reg intervalFlag_next;
  reg keypadEventFlag_reg;
  reg keypadEventFlag_next;
  reg brownoutDisable_reg;
  reg brownoutDisable_next;
  reg brownoutIrqSel_reg;
  reg brownoutIrqSel_next;
  reg lowPower_next;
  reg pointerSelect_reg;
  reg pointerSelect_next;
  reg [7:0] rdNext;

  wire wrAux = sfrWrEn && (sfrAddr == `WDSC_AUX_ADDR);
  wire wrWdcon = sfrWrEn && (sfrAddr == `WDSC_WATCHDOG_CONTROL_REG_ADDR);
  wire wrFeed = sfrWrEn && (sfrAddr == `WDSC_FEED_ADDR);
  wire wrPtrLow = sfrWrEn && (sfrAddr == `WDSC_PTRL_ADDR);
  wire wrPtrHigh = sfrWrEn && (sfrAddr == `WDSC_PTRH_ADDR);
  wire softReset = wrAux && sfrWrData[`WDSC_AUX_SOFTWARE_RESET_BIT];
  wire goodFeed = wrFeed && feedArmed_reg && (sfrWrData == `WDSC_FEED_SECOND);
  wire sfrInit = chipResetOut_reg || otherResetIn;
  wire running = (state_reg == ST_RUN);
  wire [CW-1:0] limit = BASE_CYCLES << timeoutSelect_reg;
  wire expire = running && !otherResetIn && (count_reg == limit - {{(CW-1){1'b0}}, 1'b1});

  // Enable is latched in the first cycle after reset_n and while otherResetIn is high, so software cannot alter it later
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdEnable_reg <= 1'b0;
      cfgLoaded_reg <= 1'b0;
    end else begin
      cfgLoaded_reg <= 1'b1;
      if (!cfgLoaded_reg || otherResetIn) begin
        wdEnable_reg <= watchdogEnableCfg;
      end
    end
  end

  // Reset sequencer and timeout counter
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    pulseCnt_next = pulseCnt_reg;
    pdLatched_next = pdLatched_reg;
    case (state_reg)
      ST_RUN: begin
        pulseCnt_next = 8'h00;
        if (otherResetIn) begin
          count_next = {CW{1'b0}};
        end else if (goodFeed) begin
          count_next = {CW{1'b0}};
        end else if (expire) begin
          count_next = {CW{1'b0}};
          if (wdEnable_reg) begin
            state_next = ST_PULSE;
            pdLatched_next = powerDownIn;
          end
        end else begin
          // Counts on ref_clk only, whatever the processor clock does
          count_next = count_reg + {{(CW-1){1'b0}}, 1'b1};
        end
        if (softReset) begin
          state_next = ST_PULSE;
          pdLatched_next = 1'b0;
          count_next = {CW{1'b0}};
        end
      end
      ST_PULSE: begin
        count_next = {CW{1'b0}};
        pulseCnt_next = pulseCnt_reg + 8'h01;
        if (pulseCnt_reg == PULSE_LAST) begin
          pulseCnt_next = 8'h00;
          state_next = pdLatched_reg ? ST_WAIT_OSC : ST_RUN;
        end
      end
      ST_WAIT_OSC: begin
        count_next = {CW{1'b0}};
        if (oscStableIn) begin
          state_next = ST_RUN;
          pdLatched_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_RUN;
        count_next = {CW{1'b0}};
        pulseCnt_next = 8'h00;
        pdLatched_next = 1'b0;
      end
    endcase
  end

  // Feed decoder and watchdog control register
  always @* begin
    feedArmed_next = feedArmed_reg;
    wdconLocked_next = wdconLocked_reg;
    timeoutSelect_next = timeoutSelect_reg;
    intervalFlag_next = intervalFlag_reg;
    if (wrFeed) begin
      // Wrong value only disarms; count keeps its schedule
      feedArmed_next = (sfrWrData == `WDSC_FEED_FIRST);
    end
    if (wrWdcon) begin
      if (!wdEnable_reg || !wdconLocked_reg) begin
        timeoutSelect_next = sfrWrData[`WDSC_WATCHDOG_CONTROL_REG_SEL_MSB:`WDSC_WATCHDOG_CONTROL_REG_SEL_LSB];
        wdconLocked_next = wdEnable_reg;
      end
      if (!sfrWrData[`WDSC_WATCHDOG_CONTROL_REG_FLAG]) begin
        intervalFlag_next = 1'b0;
      end
    end
    if (expire && !wdEnable_reg) begin
      intervalFlag_next = 1'b1;
    end
    if (sfrInit) begin
      feedArmed_next = 1'b0;
      wdconLocked_next = 1'b0;
      timeoutSelect_next = WATCHDOG_CONTROL_REG_RST[2:0];
      intervalFlag_next = 1'b0;
    end
  end

  // Auxiliary control register
  always @* begin
    keypadEventFlag_next = keypadEventFlag_reg;
    brownoutDisable_next = brownoutDisable_reg;
    brownoutIrqSel_next = brownoutIrqSel_reg;
    lowPower_next = epromLowPower_reg;
    pointerSelect_next = pointerSelect_reg;
    if (wrAux) begin
      keypadEventFlag_next = keypadEventFlag_reg && sfrWrData[`WDSC_AUX_KBF];
      brownoutDisable_next = sfrWrData[`WDSC_AUX_BOD];
      brownoutIrqSel_next = sfrWrData[`WDSC_AUX_BOI];
      lowPower_next = epromLowPower_reg || sfrWrData[`WDSC_AUX_EPROM_LOW_POWER];
      pointerSelect_next = sfrWrData[`WDSC_AUX_DPS];
    end
    if (keypadEventIn) begin
      keypadEventFlag_next = 1'b1;
    end
    if (sfrInit) begin
      keypadEventFlag_next = AUX_RST[`WDSC_AUX_KBF];
      brownoutDisable_next = 1'b0;
      brownoutIrqSel_next = 1'b0;
      pointerSelect_next = 1'b0;
    end
  end

  // Read data; reserved and hard-wired bits read zero
  always @* begin
    case (sfrAddr)
      `WDSC_AUX_ADDR: begin
        rdNext = {keypadEventFlag_reg, brownoutDisable_reg, brownoutIrqSel_reg, epromLowPower_reg,
                  1'b0, 1'b0, 1'b0, pointerSelect_reg};
      end
      `WDSC_WATCHDOG_CONTROL_REG_ADDR: begin
        rdNext = {2'b00, intervalFlag_reg, 2'b00, timeoutSelect_reg};
      end
      `WDSC_PTRL_ADDR: begin
        rdNext = activePointer[7:0];
      end
      `WDSC_PTRH_ADDR: begin
        rdNext = activePointer[15:8];
      end
      default: begin
        rdNext = 8'h00;
      end
    endcase
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_RUN;
      count_reg <= {CW{1'b0}};
      pulseCnt_reg <= 8'h00;
      pdLatched_reg <= 1'b0;
      feedArmed_reg <= 1'b0;
      wdconLocked_reg <= 1'b0;
      timeoutSelect_reg <= WATCHDOG_CONTROL_REG_RST[2:0];
      intervalFlag_reg <= 1'b0;
      keypadEventFlag_reg <= 1'b0;
      brownoutDisable_reg <= 1'b0;
      brownoutIrqSel_reg <= 1'b0;
      pointerSelect_reg <= 1'b0;
      epromLowPower_reg <= 1'b0;
      sfrRdData_reg <= 8'h00;
      chipResetOut_reg <= 1'b0;
      oscRestartReq_reg <= 1'b0;
      wdtIrq_reg <= 1'b0;
      brownoutDetectEn_reg <= 1'b1;
      brownoutIrqSelect_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      pulseCnt_reg <= pulseCnt_next;
      pdLatched_reg <= pdLatched_next;
      feedArmed_reg <= feedArmed_next;
      wdconLocked_reg <= wdconLocked_next;
      timeoutSelect_reg <= timeoutSelect_next;
      intervalFlag_reg <= intervalFlag_next;
      keypadEventFlag_reg <= keypadEventFlag_next;
      brownoutDisable_reg <= brownoutDisable_next;
      brownoutIrqSel_reg <= brownoutIrqSel_next;
      pointerSelect_reg <= pointerSelect_next;
      epromLowPower_reg <= lowPower_next;
      sfrRdData_reg <= rdNext;
      chipResetOut_reg <= (state_next != ST_RUN);
      oscRestartReq_reg <= (state_next != ST_RUN) && pdLatched_next;
      wdtIrq_reg <= intervalFlag_next && wdtIrqEnable && !wdEnable_reg;
      brownoutDetectEn_reg <= !brownoutDisable_next;
      brownoutIrqSelect_reg <= brownoutIrqSel_next;
    end
  end

  wdsc_ptr_bank #(
    .WIDTH(PTR_WIDTH)
  ) ptrBank (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clear(sfrInit),
    .selNext(pointerSelect_next),
    .incEn(ptrIncEn),
    .loadEn(ptrLoadEn),
    .loadData(ptrLoadData),
    .wrLowEn(wrPtrLow),
    .wrHighEn(wrPtrHigh),
    .wrByte(sfrWrData),
    .activePtr_reg(activePointer)
  );

endmodule

// File: wdsc_chk.sv
`timescale 1ns/1ps
module wdsc_chk #(
  parameter PTR_WIDTH = 16
) (
  input wire ref_clk,
  input wire reset_n,
  input wire watchdogEnableCfg,
  input wire otherResetIn,
  input wire oscStableIn,
  input wire wdtIrqEnable,
  input wire [7:0] sfrAddr,
  input wire sfrWrEn,
  input wire [7:0] sfrWrData,
  input wire ptrLoadEn,
  input wire [PTR_WIDTH-1:0] ptrLoadData,
  input wire [7:0] sfrRdData_reg,
  input wire chipResetOut_reg,
  input wire oscRestartReq_reg,
  input wire wdtIrq_reg,
  input wire brownoutDetectEn_reg,
  input wire epromLowPower_reg,
  input wire [PTR_WIDTH-1:0] activePointer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire live = !chipResetOut_reg && !otherResetIn;
  wire auxWr = sfrWrEn && sfrAddr == 8'ha2 && live;
  reg [6:0] highCnt;
  // Saturates so a long oscillator wait cannot wrap back to 50
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) highCnt <= 7'h00;
    else highCnt <= chipResetOut_reg ? highCnt + {6'h00, highCnt != 7'h7f} : 7'h00;
  end
  property p_auxZero;
    $past(sfrAddr) == 8'ha2 |-> sfrRdData_reg[3:1] == 3'h0;
  endproperty
  a_auxZero: assert property (p_auxZero) else $error("aux bits 3 to 1 read nonzero");
  property p_swReset;
    auxWr && sfrWrData[3] |-> ##[1:2] chipResetOut_reg;
  endproperty
  a_swReset: assert property (p_swReset) else $error("software reset not raised");
  property p_pulseLen;
    $fell(chipResetOut_reg) && !$past(oscRestartReq_reg) |-> highCnt == 7'h32;
  endproperty
  a_pulseLen: assert property (p_pulseLen) else $error("reset pulse not 50 cycles");
  property p_oscWait;
    $fell(chipResetOut_reg) && $past(oscRestartReq_reg) |-> $past(oscStableIn) && highCnt >= 7'h32;
  endproperty
  a_oscWait: assert property (p_oscWait) else $error("reset left before oscillator stable");
  property p_oscHold;
    oscRestartReq_reg |-> chipResetOut_reg;
  endproperty
  a_oscHold: assert property (p_oscHold) else $error("restart request outside reset");
  property p_irqGate;
    wdtIrq_reg |-> $past(wdtIrqEnable) && !$past(watchdogEnableCfg);
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("interrupt while masked or in watchdog mode");
  property p_brownout;
    auxWr && !sfrWrData[3] |-> ##2 brownoutDetectEn_reg == !$past(sfrWrData[6], 2);
  endproperty
  a_brownout: assert property (p_brownout) else $error("brownout enable not inverse of bit 6");
  property p_ptrLoad;
    ptrLoadEn && live |=> activePointer == $past(ptrLoadData);
  endproperty
  a_ptrLoad: assert property (p_ptrLoad) else $error("pointer load missed");
  property p_lpepKeep;
    chipResetOut_reg && $past(chipResetOut_reg) |-> $stable(epromLowPower_reg);
  endproperty
  a_lpepKeep: assert property (p_lpepKeep) else $error("low power bit changed in reset");
endmodule

bind wdsc_top wdsc_chk #(.PTR_WIDTH(PTR_WIDTH)) u_chk (.ref_clk, .reset_n, .watchdogEnableCfg, .otherResetIn,
  .oscStableIn, .wdtIrqEnable, .sfrAddr, .sfrWrEn, .sfrWrData, .ptrLoadEn, .ptrLoadData, .sfrRdData_reg,
  .chipResetOut_reg, .oscRestartReq_reg, .wdtIrq_reg, .brownoutDetectEn_reg, .epromLowPower_reg, .activePointer);

// File: wdsc_core_model.sv
`timescale 1ns/1ps
module wdsc_core_model (
  input wire ref_clk,
  input wire [7:0] sfrRdData_reg,
  output reg [7:0] sfrAddr,
  output reg sfrWrEn,
  output reg [7:0] sfrWrData
);
  initial begin
    sfrAddr = 8'h00;
    sfrWrEn = 1'b0;
    sfrWrData = 8'h00;
  end
  // Entered just after a rising edge; held through one sampling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      // Idle edge first so back-to-back writes never re-raise the strobe at once
      @(posedge ref_clk);
      #1;
      sfrAddr = a;
      sfrWrData = (a == 8'ha2) ? (d & 8'hfd) : d;
      sfrWrEn = 1'b1;
      @(posedge ref_clk);
      #1;
      sfrWrEn = 1'b0;
      // Released data must not look still valid
      sfrWrData = ~sfrWrData;
    end
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    begin
      sfrAddr = a;
      @(posedge ref_clk);
      #1;
      d = sfrRdData_reg;
    end
  endtask
  task feed(input logic split);
    begin
      wr(8'ha6, 8'h1e);
      if (split) wr(8'h83, 8'h5a);
      wr(8'ha6, 8'he1);
    end
  endtask
endmodule

// File: wdsc_top_test.sv
`timescale 1ns/1ps
module wdsc_top_test;
  localparam int BASE = 20;
  logic ref_clk = 1'b0, reset_n = 1'b0, watchdogEnableCfg = 1'b0, otherResetIn = 1'b0, powerDownIn = 1'b0;
  logic oscStableIn = 1'b1, keypadEventIn = 1'b0, wdtIrqEnable = 1'b1, ptrIncEn = 1'b0, ptrLoadEn = 1'b0;
  logic [15:0] ptrLoadData = 16'h0000, activePointer;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData_reg, rdv, d;
  logic sfrWrEn, chipResetOut_reg, oscRestartReq_reg, wdtIrq_reg;
  logic brownoutDetectEn_reg, brownoutIrqSelect_reg, epromLowPower_reg;
  int num_errors = 0, cmp_count = 0, rises = 0, n, eprom_low_power = 0;
  int ptrs[2];
  int auxQ[$];
  always #10 ref_clk = ~ref_clk;
  always @(posedge chipResetOut_reg) rises++;
  wdsc_top #(.BASE_CYCLES(28'h14), .PTR_WIDTH(16)) dut (.ref_clk, .reset_n, .watchdogEnableCfg, .otherResetIn,
    .powerDownIn, .oscStableIn, .keypadEventIn, .wdtIrqEnable, .sfrAddr, .sfrWrEn, .sfrWrData, .ptrIncEn,
    .ptrLoadEn, .ptrLoadData, .sfrRdData_reg, .chipResetOut_reg, .oscRestartReq_reg, .wdtIrq_reg,
    .brownoutDetectEn_reg, .brownoutIrqSelect_reg, .epromLowPower_reg, .activePointer);
  wdsc_core_model core (.ref_clk, .sfrRdData_reg, .sfrAddr, .sfrWrEn, .sfrWrData);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic waitRst(input logic lvl, output int k);
    k = 0;
    while (chipResetOut_reg !== lvl && k < 5000) begin
      cyc(1);
      k++;
    end
  endtask
  // Good feed, then a broken one that must not move the deadline
  task automatic timed(input int sel);
    int k;
    core.feed(1'b0);
    core.wr(8'ha6, 8'h1e);
    core.wr(8'ha6, 8'h55);
    waitRst(1'b1, k);
    k = k + 4;
    chk("expiry", k >= (BASE << sel) - 2 && k <= (BASE << sel) + 2, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The run needs under 2000 cycles
  initial begin
    #400000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'hd1f4b470));
    cyc(12);
    reset_n = 1'b1;
    chk("bodEnReset", brownoutDetectEn_reg, 1'b1);
    core.rd(8'ha2, rdv);
    chk("auxReset", rdv, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) & 8'h77;
      core.wr(8'ha2, d);
      if (d[4]) eprom_low_power = 1;
      auxQ.push_back({1'b0, d[6:5], eprom_low_power[0], 3'h0, d[0]});
      core.rd(8'ha2, rdv);
      chk("aux", rdv, auxQ.pop_front());
      chk("bodEn", brownoutDetectEn_reg, !d[6]);
      chk("boi", brownoutIrqSelect_reg, d[5]);
      chk("eprom_low_power", epromLowPower_reg, eprom_low_power);
    end
    keypadEventIn = 1'b1;
    cyc(1);
    keypadEventIn = 1'b0;
    core.rd(8'ha2, rdv);
    chk("auxKbf", rdv, {1'b1, d[6:5], eprom_low_power[0], 3'h0, d[0]});
    for (int s = 0; s < 2; s++) begin
      core.wr(8'ha2, 8'(s));
      ptrs[s] = $urandom & 32'hffff;
      ptrLoadData = ptrs[s][15:0];
      ptrLoadEn = 1'b1;
      cyc(1);
      ptrLoadEn = 1'b0;
      chk("ptrLoad", activePointer, ptrs[s]);
    end
    core.wr(8'ha2, 8'h00);
    cyc(1);
    chk("ptrSel0", activePointer, ptrs[0]);
    ptrIncEn = 1'b1;
    cyc(1);
    ptrIncEn = 1'b0;
    chk("ptrInc", activePointer, (ptrs[0] + 1) & 32'hffff);
    core.wr(8'h82, 8'h3c);
    core.rd(8'h82, rdv);
    chk("ptrLow", rdv, 8'h3c);
    core.wr(8'ha2, 8'h01);
    cyc(1);
    chk("ptrSel1", activePointer, ptrs[1]);
    // Clear first so the wait below locks onto a fresh expiry
    core.wr(8'ha7, 8'h00);
    n = 0;
    while (wdtIrq_reg !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("irqRaised", wdtIrq_reg, 1'b1);
    core.wr(8'ha7, 8'h00);
    cyc(1);
    chk("irqCleared", wdtIrq_reg, 1'b0);
    wdtIrqEnable = 1'b0;
    cyc(2 * BASE);
    chk("irqMasked", wdtIrq_reg, 1'b0);
    wdtIrqEnable = 1'b1;
    cyc(2);
    chk("irqPending", wdtIrq_reg, 1'b1);
    chk("intervalNoReset", rises, 0);
    core.wr(8'ha2, 8'h18);
    waitRst(1'b1, n);
    chk("srstDelay", n <= 2, 1'b1);
    waitRst(1'b0, n);
    chk("srstPulse", n, 50);
    core.rd(8'ha2, rdv);
    chk("auxAfterSrst", rdv, 8'h10);
    chk("ptrAfterSrst", activePointer, 0);
    reset_n = 1'b0;
    watchdogEnableCfg = 1'b1;
    cyc(2);
    reset_n = 1'b1;
    rises = 0;
    repeat (6) begin
      core.feed(1'b1);
      cyc(12);
    end
    chk("fedNoReset", rises, 0);
    timed(0);
    waitRst(1'b0, n);
    chk("wdPulse", n, 50);
    core.feed(1'b0);
    core.wr(8'ha7, 8'h01);
    core.wr(8'ha7, 8'h07);
    timed(1);
    waitRst(1'b0, n);
    powerDownIn = 1'b1;
    oscStableIn = 1'b0;
    waitRst(1'b1, n);
    cyc(60);
    chk("oscWaitRst", chipResetOut_reg, 1'b1);
    chk("oscReq", oscRestartReq_reg, 1'b1);
    oscStableIn = 1'b1;
    waitRst(1'b0, n);
    chk("oscRelease", n <= 2, 1'b1);
    powerDownIn = 1'b0;
    core.feed(1'b0);
    otherResetIn = 1'b1;
    rises = 0;
    cyc(100);
    chk("heldByOther", rises, 0);
    otherResetIn = 1'b0;
    waitRst(1'b1, n);
    chk("expiryAfterOther", n >= BASE - 2 && n <= BASE + 2, 1'b1);
    report_and_stop;
  end
endmodule
